// ==== ics_pkg.sv ====
// Constants, types and the class decoder for the counter sequencer.
// Assumes one pclk domain and registers reached over APB.
package ics_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INSTR = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_COUNTS = 8'h0c;
   localparam logic [7:0] ADDR_DONE = 8'h10;
   // Reset values
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [31:0] INSTR_RST = 32'h0;
   // Instruction register field positions
   localparam int F_OP = 0;
   localparam int F_CFG = 5;
   localparam int F_STEP = 9;
   localparam int F_ALAST = 15;
   localparam int F_SCLEN = 20;
   // Counter time states
   localparam logic [4:0] ST_00 = 5'h00;
   localparam logic [4:0] ST_01 = 5'h01;
   localparam logic [4:0] ST_13 = 5'h0d;
   localparam logic [4:0] ST_14 = 5'h0e;
   localparam logic [4:0] ST_20 = 5'h14;
   localparam logic [4:0] ST_22 = 5'h16;
   localparam logic [4:0] ST_24 = 5'h18;
   localparam logic [4:0] ST_25 = 5'h19;
   localparam logic [4:0] ST_26 = 5'h1a;
   localparam logic [4:0] ST_31 = 5'h1f;
   // Default counter lengths
   localparam logic [4:0] CFG_LAST = 5'h07;
   localparam logic [4:0] IDX_LAST = 5'h03;
   // Operation codes
   localparam logic [4:0] plain_jump_code = 5'h00;
   localparam logic [4:0] OP_JUMP_IDX = 5'h01;
   localparam logic [4:0] inout_select_code = 5'h02;
   localparam logic [4:0] arithmetic_operate_code = 5'h03;
   localparam logic [4:0] OP_JUMP_ACC = 5'h04;
   localparam logic [4:0] skip_on_memory_code = 5'h05;
   localparam logic [4:0] transfer_store_code = 5'h06;
   localparam logic [4:0] skip_on_equality_code = 5'h07;
   localparam logic [4:0] OP_LOAD = 5'h08;
   localparam logic [4:0] operate_code = 5'h09;
   localparam logic [4:0] special_config_code_a = 5'h0a;
   localparam logic [4:0] special_config_code_b = 5'h0b;
   localparam logic [4:0] flag_code_a = 5'h0c;
   localparam logic [4:0] flag_code_b = 5'h0d;
   localparam logic [4:0] OP_ADD = 5'h0e;
   localparam logic [4:0] OP_SUB = 5'h0f;
   localparam logic [4:0] difference_code = 5'h10;
   localparam logic [4:0] OP_MUL = 5'h11;
   localparam logic [4:0] OP_CYCLE = 5'h12;
   localparam logic [4:0] OP_SCALE = 5'h13;
   localparam logic [4:0] OP_IDX_XCHG = 5'h14;

   typedef enum logic [3:0] {
      CL_A1 = 4'h0, CL_A2 = 4'h1, CL_A3 = 4'h2, CL_A4 = 4'h3,
      CL_B1 = 4'h4, CL_B2 = 4'h5, CL_B3 = 4'h6, CL_C1 = 4'h7,
      CL_C2 = 4'h8, CL_C3 = 4'h9, CL_C4 = 4'ha, CL_C5 = 4'hb,
      CL_C6 = 4'hc
   } ics_class_type;

   // Unlisted codes behave as typical class C instructions
   function automatic ics_class_type ics_classify(input logic [4:0] op);
      case (op)
         plain_jump_code, OP_JUMP_IDX: ics_classify = CL_A1;
         inout_select_code: ics_classify = CL_A2;
         arithmetic_operate_code: ics_classify = CL_A3;
         OP_JUMP_ACC: ics_classify = CL_A4;
         skip_on_memory_code: ics_classify = CL_B1;
         transfer_store_code: ics_classify = CL_B2;
         skip_on_equality_code: ics_classify = CL_B3;
         special_config_code_a, special_config_code_b: ics_classify = CL_C2;
         flag_code_a, flag_code_b: ics_classify = CL_C3;
         OP_ADD, OP_SUB, difference_code: ics_classify = CL_C4;
         OP_MUL, OP_CYCLE, OP_SCALE: ics_classify = CL_C5;
         OP_IDX_XCHG: ics_classify = CL_C6;
         default: ics_classify = CL_C1;
      endcase
   endfunction : ics_classify
endpackage : ics_pkg

// ==== ics_sequencer.sv ====
// Counter sequencer: instruction, operand and helper control counters.
// Assumes synchronous inputs on pclk and an APB master for registers.

// One control counter: a request waits until the counter is idle and
// its gate is open, then the state runs 0..last and stops.
module ics_count (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic ce, // Clock enable
   input wire logic trig, // Start request
   input wire logic gate, // Start permitted
   input wire logic [4:0] last, // Final state
   output logic pend, // Request waiting
   output logic run, // Counter active
   output logic fin, // Pulse after final state
   output logic [4:0] state // Time state
);
   wire go = pend && !run && gate;
   wire at_end = run && (state == last);

   // Queue, run and stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 1'b0;
         run <= 1'b0;
         fin <= 1'b0;
         state <= 5'h00;
      end else if (ce) begin
         pend <= trig || (pend && !go);
         fin <= at_end;
         if (go) begin
            run <= 1'b1;
            state <= 5'h00;
         end else if (at_end) begin
            run <= 1'b0;
         end else if (run) begin
            state <= state + 5'h01;
         end
      end
   end
endmodule : ics_count

module ics_sequencer #(
   parameter logic [4:0] CFG_LEN = ics_pkg::CFG_LAST, // Config cycle last state
   parameter logic [4:0] IDX_LEN = ics_pkg::IDX_LAST // Index cycle last state
) (
   input wire logic pclk, // Clock, 20 MHz
   input wire logic presetn, // Async reset, low
   input wire logic pce, // Clock enable
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic element_busy_flag, // In-out element busy
   input wire logic arith_element_busy, // Arithmetic element busy
   input wire logic instruction_interlock_bit4, // Store wait select
   input wire logic jump_wait, // Class A4 wait condition
   input wire logic cfg_start_ok, // Class A4 config start interlock
   output logic [4:0] instruction_counter, // Instruction time state
   output logic ic_run, // Instruction counter active
   output logic [4:0] operand_counter, // Operand time state
   output logic oc_run, // Operand counter active
   output logic [4:0] configuration_counter, // Config time state
   output logic cfg_run, // Config counter active
   output logic [4:0] index_word_counter, // Index time state
   output logic idx_run, // Index counter active
   output logic [4:0] arithmetic_counter, // Arithmetic time state
   output logic arith_run, // Arithmetic counter active
   output logic [5:0] arithmetic_step_counter, // Subcycle count
   output logic step_run, // Step counter in use
   output logic execute_instruction_phase, // States 25..31
   output logic instruction_memory_phase, // States 00..22
   output logic addr_modify, // Index register modifies address
   output logic config_control, // Standard config control active
   output logic [3:0] operand_cycle_config_register, // Config bits
   output logic pc_alter_window // Program address may change
);
   typedef ics_pkg::ics_class_type ics_cls_type;

   logic [1:0] ctrl;
   logic [31:0] instr;
   logic start_req, ic_new, reached;
   logic [15:0] done_cnt;
   logic [4:0] ic_op, next_ic;
   logic [3:0] instruction_cycle_config_register;
   logic next_ic_run;
   ics_cls_type ic_cls, oc_cls, pend_cls;
   logic cfg_a4, cfg_spec, cfg_std, a_c5, a_cysc;
   logic oc_pend, oc_fin, cfg_pend, cfg_fin, idx_pend, arith_pend, arith_fin;

   // APB decode
   wire acc = psel && penable;
   wire hit_ctrl = paddr == ics_pkg::ADDR_CTRL;
   wire hit_instr = paddr == ics_pkg::ADDR_INSTR;
   wire hit_stat = paddr == ics_pkg::ADDR_STATUS;
   wire hit_cnt = paddr == ics_pkg::ADDR_COUNTS;
   wire hit_done = paddr == ics_pkg::ADDR_DONE;
   wire mapped = hit_ctrl || hit_instr || hit_stat || hit_cnt || hit_done;
   wire wr = acc && pready && pwrite && mapped;
   wire [31:0] rd_mux =
      hit_ctrl ? {30'h0, ctrl} :
      hit_instr ? instr :
      hit_stat ? {16'h0, ic_cls, oc_run, ic_run, operand_counter, instruction_counter} :
      hit_cnt ? {7'h0, arithmetic_step_counter, arithmetic_counter, index_word_counter,
                 configuration_counter, 4'h0} :
      hit_done ? {16'h0, done_cnt} : 32'h0;

   // Instruction register fields
   wire [4:0] f_op = instr[ics_pkg::F_OP +: 5];
   wire [5:0] f_step = instr[ics_pkg::F_STEP +: 6];
   wire [4:0] f_alast = instr[ics_pkg::F_ALAST +: 5];
   wire [4:0] f_sclen = instr[ics_pkg::F_SCLEN +: 5];

   // Class groupings of the running instruction
   wire ic_a = ic_cls <= ics_pkg::CL_A4;
   wire ic_c = ic_cls >= ics_pkg::CL_C1;
   wire ic_has_oc = !ic_a;
   wire ic = ic_run;
   wire [4:0] ics = instruction_counter;
   wire at13 = ic && ic_new && ics == ics_pkg::ST_13;
   wire at14 = ic && ic_new && ics == ics_pkg::ST_14;
   wire at24 = ic && ic_new && ics == ics_pkg::ST_24;
   wire at26 = ic && ic_new && ics == ics_pkg::ST_26;
   wire at31 = ic && ic_new && ics == ics_pkg::ST_31;
   wire oc13 = oc_run && operand_counter == ics_pkg::ST_13;
   wire oc14 = oc_run && operand_counter == ics_pkg::ST_14;
   wire oc00 = oc_run && operand_counter == ics_pkg::ST_00;

   // Operand target for class B waits; an older operand cycle still counts until our request queues
   wire [4:0] oc_tgt = (ic_cls == ics_pkg::CL_B2) ?
      (instruction_interlock_bit4 ? ics_pkg::ST_01 : ics_pkg::ST_20) :
      ics_pkg::ST_14;
   wire oc_hit = oc_run && !oc_pend && operand_counter == oc_tgt;

   // Wait conditions that hold the instruction counter at 25
   wire ic_wait =
      (ic_cls == ics_pkg::CL_A2) ? element_busy_flag :
      (ic_cls == ics_pkg::CL_A3) ? (arith_element_busy || arith_run || arith_pend) :
      (ic_cls == ics_pkg::CL_A4) ? jump_wait :
      (ic_cls == ics_pkg::CL_B1 || ic_cls == ics_pkg::CL_B2 ||
       ic_cls == ics_pkg::CL_B3) ? !(reached || oc_hit) : 1'b0;

   wire go_instr = !ic_run && (start_req || ctrl[1]);

   // Instruction counter sequence; 23 and memory skips are not modelled
   always_comb begin
      next_ic_run = ic_run;
      next_ic = instruction_counter;
      if (!ic_run) begin
         if (go_instr) begin
            next_ic_run = 1'b1;
            next_ic = ics_pkg::ST_00;
         end
      end else if (ics == ics_pkg::ST_22) begin
         // One operand request queues at a time, so the next waits here
         if (!(ic_has_oc && oc_pend)) next_ic = ics_pkg::ST_24;
      end else if (ics == ics_pkg::ST_24) begin
         if (ic_c) next_ic_run = 1'b0;
         else next_ic = ics_pkg::ST_25;
      end else if (ics == ics_pkg::ST_25) begin
         if (!ic_wait) next_ic = ics_pkg::ST_26;
      end else if (ics == ics_pkg::ST_31) begin
         next_ic_run = 1'b0;
      end else begin
         next_ic = ics + 5'h01;
      end
   end

   // Counter requests
   wire oc_gate = !(oc_pend && pend_cls == ics_pkg::CL_C3) ||
      (!cfg_pend && !cfg_run);
   wire oc_go = oc_pend && !oc_run && oc_gate;
   wire oc_trig = at24 && ic_has_oc;
   wire cfg_oc_std = oc_cls == ics_pkg::CL_B2 || oc_cls == ics_pkg::CL_B3 ||
      oc_cls == ics_pkg::CL_C1 || oc_cls == ics_pkg::CL_C4 ||
      oc_cls == ics_pkg::CL_C5 || oc_cls == ics_pkg::CL_C6;
   wire cfg_ic_trig = at13 && (ic_cls == ics_pkg::CL_A4 || ic_cls == ics_pkg::CL_C3);
   wire cfg_trig = cfg_ic_trig || (oc00 && cfg_oc_std) ||
      (oc13 && oc_cls == ics_pkg::CL_C2);
   wire jmp_no_idx = ic_op == ics_pkg::plain_jump_code &&
      instruction_cycle_config_register[2];
   wire idx_ic14 = at14 && ic_cls != ics_pkg::CL_A1;
   wire idx_trig = idx_ic14 || (at31 && ic_cls == ics_pkg::CL_A1 && !jmp_no_idx) ||
      (oc14 && oc_cls == ics_pkg::CL_C6);
   wire uses_x = ic_op != ics_pkg::skip_on_memory_code && ic_op != ics_pkg::operate_code;
   wire arith_first = (at26 && ic_cls == ics_pkg::CL_A3) ||
      (oc14 && (oc_cls == ics_pkg::CL_C4 || oc_cls == ics_pkg::CL_C5));
   wire [5:0] sub_next = arithmetic_step_counter + 6'h01;
   wire more_sub = arith_fin && a_c5 && sub_next < f_step;

   ics_count u_oc (.pclk(pclk), .presetn(presetn), .ce(pce), .trig(oc_trig),
      .gate(oc_gate), .last(ics_pkg::ST_31), .pend(oc_pend), .run(oc_run),
      .fin(oc_fin), .state(operand_counter));
   ics_count u_cfg (.pclk(pclk), .presetn(presetn), .ce(pce), .trig(cfg_trig),
      .gate(!cfg_a4 || cfg_start_ok), .last(cfg_spec ? f_sclen : CFG_LEN),
      .pend(cfg_pend), .run(cfg_run), .fin(cfg_fin),
      .state(configuration_counter));
   ics_count u_idx (.pclk(pclk), .presetn(presetn), .ce(pce), .trig(idx_trig),
      .gate(1'b1), .last(IDX_LEN), .pend(idx_pend), .run(idx_run), .fin(),
      .state(index_word_counter));
   ics_count u_ar (.pclk(pclk), .presetn(presetn), .ce(pce),
      .trig(arith_first || more_sub), .gate(1'b1), .last(f_alast),
      .pend(arith_pend), .run(arith_run), .fin(arith_fin),
      .state(arithmetic_counter));

   // APB slave, one wait state on every access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         ctrl <= ics_pkg::CTRL_RST;
         instr <= ics_pkg::INSTR_RST;
      end else if (pce) begin
         pready <= acc && !pready;
         pslverr <= acc && !pready && !mapped;
         if (acc && !pready) prdata <= rd_mux;
         if (wr && hit_ctrl) ctrl <= pwdata[1:0];
         if (wr && hit_instr) instr <= pwdata;
      end
   end

   // Instruction counter and its latched instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ic_run <= 1'b0;
         instruction_counter <= 5'h00;
         ic_new <= 1'b0;
         start_req <= 1'b0;
         ic_op <= 5'h00;
         ic_cls <= ics_pkg::CL_A1;
         instruction_cycle_config_register <= 4'h0;
         reached <= 1'b0;
         done_cnt <= 16'h0;
      end else if (pce) begin
         ic_run <= next_ic_run;
         instruction_counter <= next_ic;
         ic_new <= next_ic_run && (go_instr || next_ic != instruction_counter);
         // Start request set wins over its clear by the start
         start_req <= (wr && hit_ctrl && pwdata[0]) || (start_req && !go_instr);
         if (go_instr) begin
            ic_op <= f_op;
            ic_cls <= ics_pkg::ics_classify(f_op);
            instruction_cycle_config_register <= instr[ics_pkg::F_CFG +: 4];
         end
         reached <= oc_hit || (reached && !go_instr);
         if (ic_run && !next_ic_run) done_cnt <= done_cnt + 16'h0001;
      end
   end

   // Operand ownership, config and arithmetic attributes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_cls <= ics_pkg::CL_C1;
         oc_cls <= ics_pkg::CL_C1;
         operand_cycle_config_register <= 4'h0;
         {cfg_a4, cfg_spec, cfg_std, a_c5, a_cysc} <= 5'h00;
         arithmetic_step_counter <= 6'h00;
      end else if (pce) begin
         if (oc_trig) pend_cls <= ic_cls;
         if (oc_go) begin
            oc_cls <= pend_cls;
            operand_cycle_config_register <= instruction_cycle_config_register;
         end
         if (cfg_trig) begin
            cfg_a4 <= cfg_ic_trig && ic_cls == ics_pkg::CL_A4;
            cfg_spec <= oc13 && oc_cls == ics_pkg::CL_C2;
            cfg_std <= !(cfg_ic_trig && ic_cls == ics_pkg::CL_C3) &&
               !(oc13 && oc_cls == ics_pkg::CL_C2);
         end
         if (arith_first) begin
            a_c5 <= oc14 && oc_cls == ics_pkg::CL_C5;
            a_cysc <= ic_op == ics_pkg::OP_CYCLE || ic_op == ics_pkg::OP_SCALE;
            arithmetic_step_counter <= 6'h00;
         end else if (more_sub) begin
            arithmetic_step_counter <= sub_next;
         end
      end
   end

   // Registered phase and control levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         execute_instruction_phase <= 1'b0;
         instruction_memory_phase <= 1'b0;
         pc_alter_window <= 1'b0;
         addr_modify <= 1'b0;
         config_control <= 1'b0;
         step_run <= 1'b0;
      end else if (pce) begin
         execute_instruction_phase <= next_ic_run && next_ic >= ics_pkg::ST_25;
         instruction_memory_phase <= next_ic_run && next_ic <= ics_pkg::ST_22;
         pc_alter_window <= next_ic_run && next_ic >= ics_pkg::ST_25 &&
            ic_op != ics_pkg::transfer_store_code;
         addr_modify <= idx_ic14 && uses_x;
         config_control <= cfg_run && cfg_std && !cfg_fin;
         step_run <= a_c5 && !a_cysc && (arith_run || arith_pend);
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn || !pce);

   class_a_exec_a: assert property (ic_run && ics == ics_pkg::ST_24 && ic_a
      |=> ic_run && instruction_counter == ics_pkg::ST_25)
      else $error("class A left state 24 wrongly");
   class_c_end_a: assert property (ic_run && ics == ics_pkg::ST_24 && ic_c |=> !ic_run)
      else $error("class C did not end at 24");
   mem_to_24_a: assert property (ic_run && ics == ics_pkg::ST_22 && !oc_pend
      |=> instruction_counter == ics_pkg::ST_24)
      else $error("state 22 not followed by 24");
   exec_phase_a: assert property (execute_instruction_phase |-> ic_run &&
      ics >= ics_pkg::ST_25)
      else $error("execute phase outside 25..31");
   busy_hold_a: assert property (ic_run && ics == ics_pkg::ST_25 &&
      ic_cls == ics_pkg::CL_A2 && element_busy_flag |=> ics == ics_pkg::ST_25)
      else $error("in-out select left 25 while busy");
   arith_26_a: assert property (ic_run && ics == ics_pkg::ST_26 && ic_new &&
      ic_cls == ics_pkg::CL_A3 |=> arith_pend ##1 arith_run)
      else $error("arithmetic counter not started at 26");
   oc_end_a: assert property ($fell(oc_run) |-> $past(operand_counter) == ics_pkg::ST_31)
      else $error("operand cycle ended off 31");
   store_wait_a: assert property (ic_run && $past(ics) == ics_pkg::ST_25 &&
      ics == ics_pkg::ST_26 && ic_cls == ics_pkg::CL_B2 |-> $past(reached || oc_hit))
      else $error("transfer-store left 25 early");
   idx_default_a: assert property (idx_ic14 |=> idx_pend ##1 idx_run)
      else $error("index counter not started at 14");
   wait_release_a: assert property (ic_run && ics == ics_pkg::ST_25 && !ic_wait
      |=> ics == ics_pkg::ST_26)
      else $error("counter did not advance after wait");

   c_done_c: cover property (ic_run && ic_c ##1 !ic_run);
   b2_wait_c: cover property (ic_cls == ics_pkg::CL_B2 && ics == ics_pkg::ST_25 [*3]);
   c5_sub_c: cover property (more_sub);
   flag_c: cover property (cfg_run && pend_cls == ics_pkg::CL_C3 && oc_pend);
endmodule : ics_sequencer

// ==== ics_far_model.sv ====
// Far-side model: in-out and arithmetic elements and interlock control.
// Assumes the bench sets the busy span; an int counter needs no reset.
module ics_far_model (
   input wire logic pclk, // Clock
   input wire logic ic_run, // Instruction counter active
   input wire logic [4:0] instruction_counter, // Instruction state
   input wire logic [7:0] busy_len, // Busy span, cycles
   output logic busy // Element busy, shared by all waits
);
   int cnt = 0;
   // A prior job holds the element from state 24 on, so waits really bite
   always @(posedge pclk) begin
      if (ic_run && instruction_counter == ics_pkg::ST_24) cnt <= busy_len;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   assign busy = cnt > 0;
endmodule : ics_far_model

// ==== instruction_class_counter_sequencer_test.sv ====
// Bench: APB tasks, far-side busy model and counter timing checks.
// Assumes ics_pkg, ics_sequencer and ics_far_model compiled first.
module instruction_class_counter_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'h0, presetn = 1'h0, pce = 1'h1, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, bit4 = 1'h0, e, pready, pslverr, busy, ic_run, oc_run;
   logic cfg_run, idx_run, arith_run, step_run, exe, am, ccl, pa, mp;
   logic [4:0] ic, oc;
   logic [7:0] paddr = 8'h00, busy_len = 8'h01;
   logic [31:0] pwdata = 32'h0, prdata, w, q;
   int error_cnt = 0, check_count = 0, seed, op, cyc = 0, qt, mx, ox, h, o26, t;
   int am_n, cc_n, st_n, ii, ci, co, ao;
   // Default counter lengths; unused state outputs open
   ics_sequencer DUT (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .element_busy_flag(busy), .arith_element_busy(busy),
      .instruction_interlock_bit4(bit4), .jump_wait(busy), .cfg_start_ok(!busy),
      .instruction_counter(ic), .ic_run, .operand_counter(oc), .oc_run,
      .configuration_counter(), .cfg_run, .index_word_counter(), .idx_run,
      .arithmetic_counter(), .arith_run, .arithmetic_step_counter(), .step_run,
      .execute_instruction_phase(exe), .instruction_memory_phase(mp), .addr_modify(am),
      .config_control(ccl), .operand_cycle_config_register(), .pc_alter_window(pa));
   ics_far_model far (.pclk, .ic_run, .instruction_counter(ic), .busy_len, .busy);
   // 20 MHz clock
   always #25 pclk = ~pclk;
   // Hang guard, far above the run length
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   task chk(input string s, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", s, x, g);
      end
   endtask : chk
   task final_report();
      if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // One APB transfer after an idle edge; held until pready
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // Reset, register checks, then every code once
   initial begin
      seed = 77;
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, ics_pkg::ADDR_INSTR, 32'h0);
      chk("instr_rst", ics_pkg::INSTR_RST, q);
      apb(1'h1, 8'h20, 32'h5);
      chk("unmapped", 32'h1, {31'h0, e});
      for (op = 0; op < 21; op++) begin
         busy_len <= 8'($random(seed) & 7) + 8'h01;
         bit4 <= 1'($random(seed));
         w = {7'h00, 5'h03, 5'h03, 6'h02, 4'($random(seed)), 5'(op)};
         apb(1'h1, ics_pkg::ADDR_INSTR, w);
         apb(1'h0, ics_pkg::ADDR_INSTR, 32'h0);
         chk("instr_rb", w, q);
         apb(1'h1, ics_pkg::ADDR_CTRL, 32'h1);
         {qt, mx, ox, h, am_n, cc_n, st_n} = '0;
         {ii, ci, co, ao, o26} = {5{32'hffffffff}};
         // Sample settled outputs until all counters stay idle
         while (qt < 6) begin
            @(posedge pclk);
            chk("exec", ic_run && ic >= ics_pkg::ST_25, exe);
            chk("mem_ph", ic_run && ic <= ics_pkg::ST_22, mp);
            chk("pc_alt", ic_run && ic >= ics_pkg::ST_25 && op != 6, pa);
            if (ic_run === 1'h1 && ic > mx) mx = ic;
            if (ic_run === 1'h1 && ic == ics_pkg::ST_25) h++;
            if (ic_run === 1'h1 && ic == ics_pkg::ST_26 && o26 < 0) o26 = oc;
            if (oc_run === 1'h1 && ox == 0) chk("oc_go", 1, mx >= 24);
            if (oc_run === 1'h1 && oc > ox) ox = oc;
            if (idx_run === 1'h1 && ic_run === 1'h1 && ii < 0) ii = ic;
            if (cfg_run === 1'h1 && ci < 0) ci = ic;
            if (cfg_run === 1'h1 && co < 0) co = oc;
            if (arith_run === 1'h1 && ao < 0) ao = oc;
            am_n += am;
            cc_n += ccl;
            st_n += step_run;
            qt = (mx > 0 && !(ic_run | oc_run | cfg_run | idx_run | arith_run)) ? qt + 1 : 0;
         end
         chk("ic_end", op > 7 ? 24 : 31, mx);
         chk("oc_end", op > 4 ? 31 : 0, ox);
         chk("addr_mod", !(op < 2 || op == 5 || op == 9), am_n);
         chk("cfg_ctl", !(op < 4 || op == 5 || op inside {[10:13]}), cc_n > 0);
         chk("step", op == 17, st_n > 0);
         chk("idx_go", op < 2 ? -1 : 16, ii);
         if (op == 12 || op == 13) chk("cfg_flag", 15, ci);
         else if (op == 10 || op == 11) chk("cfg_spec", 15, co);
         else if (op > 5) chk("cfg_go", 2, co);
         else chk("cfg_none", op == 4, ci >= 0);
         if (op > 13 && op < 17) chk("arith_go", 16, ao);
         if (op > 1 && op < 5)
            chk("hold", 1, h > busy_len && h < busy_len + 3);
         t = op == 6 ? (bit4 ? 1 : 20) : 14;
         if (op > 4 && op < 8)
            chk("b_wait", 1, o26 >= t && o26 < t + 3);
      end
      apb(1'h0, ics_pkg::ADDR_DONE, 32'h0);
      chk("done", 21, q & 32'hffff);
      final_report();
   end
endmodule : instruction_class_counter_sequencer_test
